// file: iec_enable_bank.sv
// Overview of operation
// R1 - Enable six bit 10 enables self-tune request; clears at reset.
// R2 - Other bits of enable register six read zero and ignore writes.
// R3 - Bit 5 of enable register seven enables JTAG request; clears at reset.
// R4 - Bits 15 to 6 of enable register seven read zero.
// R5 - Bits 4 to 0 of enable register seven read zero.
// R6 - Enable bit one enables its request, zero leaves it disabled.
// R7 - Requests reach priority logic only while enabled; flags still set.
`include "iec_regs.svh"

module iec_enable_bank
  import iec_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        selftune_event,
  input  wire logic        jtag_event,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  output logic             selftune_req,
  output logic             jtag_req,
  output iec_prio_t        timer_one_priority,
  output iec_prio_t        compare_one_priority,
  output iec_prio_t        capture_one_priority,
  output iec_prio_t        ext_int_zero_priority,
  output logic             irq
);
  localparam int NS = `IEC_NUM_SRC;

  function automatic iec_sel_t decode(input logic [11:0] a);
    unique case (a)
      `IEC_OFS_EN_SIX:      decode = IEC_SEL_EN_SIX;
      `IEC_OFS_EN_SEVEN:    decode = IEC_SEL_EN_SEVEN;
      `IEC_OFS_PRIO_ZERO:   decode = IEC_SEL_PRIO_ZERO;
      `IEC_OFS_FLAG_STATUS: decode = IEC_SEL_FLAG_STATUS;
      `IEC_OFS_FLAG_CLEAR:  decode = IEC_SEL_FLAG_CLEAR;
      `IEC_OFS_FLAG_ENABLE: decode = IEC_SEL_FLAG_ENABLE;
      default:              decode = IEC_SEL_NONE;
    endcase
  endfunction : decode

  function automatic iec_word_t prio_word(input iec_prio_t t,
                                          input iec_prio_t o,
                                          input iec_prio_t c,
                                          input iec_prio_t e);
    prio_word = '0;
    prio_word[`IEC_POS_TIMER_ONE +: 3]    = t;
    prio_word[`IEC_POS_COMPARE_ONE +: 3]  = o;
    prio_word[`IEC_POS_CAPTURE_ONE +: 3]  = c;
    prio_word[`IEC_POS_EXT_INT_ZERO +: 3] = e;
  endfunction : prio_word

  logic            osc_selftune_irq_en_reg;
  logic            jtag_irq_en_reg;
  iec_prio_t       timer_prio_reg;
  iec_prio_t       compare_prio_reg;
  iec_prio_t       capture_prio_reg;
  iec_prio_t       ext_prio_reg;
  logic [NS-1:0]   flag_reg;
  logic [NS-1:0]   req_reg;
  logic [NS-1:0]   enable_vec;
  logic [NS-1:0]   event_vec;
  logic [NS-1:0]   clear_vec;
  logic            wr_commit;
  iec_sel_t        sel;
  iec_word_t       rd_value;
  iec_word_t       wd;
  logic            irq_reg;

  assign sel       = decode(paddr);
  assign wd        = pwdata[15:0];
  // Writes land only on the edge where the access phase completes
  assign wr_commit = psel & penable & pready & pwrite & ~pslverr;

  assign enable_vec[`IEC_FLAG_SELFTUNE] = osc_selftune_irq_en_reg;
  assign enable_vec[`IEC_FLAG_JTAG]     = jtag_irq_en_reg;
  assign event_vec[`IEC_FLAG_SELFTUNE]  = selftune_event;
  assign event_vec[`IEC_FLAG_JTAG]      = jtag_event;
  assign clear_vec = (wr_commit && sel == IEC_SEL_FLAG_CLEAR) ?
                     wd[NS-1:0] : '0;

  // Only the documented enable bits have storage; the rest never hold data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_selftune_irq_en_reg <= 1'b0; // R1
    end else if (wr_commit && sel == IEC_SEL_EN_SIX) begin
      osc_selftune_irq_en_reg <= wd[`IEC_BIT_SELFTUNE_EN]; // R1 R2
    end else if (wr_commit && sel == IEC_SEL_FLAG_ENABLE) begin
      osc_selftune_irq_en_reg <= wd[`IEC_FLAG_SELFTUNE];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      jtag_irq_en_reg <= 1'b0; // R3
    end else if (wr_commit && sel == IEC_SEL_EN_SEVEN) begin
      jtag_irq_en_reg <= wd[`IEC_BIT_JTAG_EN]; // R3
    end else if (wr_commit && sel == IEC_SEL_FLAG_ENABLE) begin
      jtag_irq_en_reg <= wd[`IEC_FLAG_JTAG];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_prio_reg   <= `IEC_PRIO_RESET;
      compare_prio_reg <= `IEC_PRIO_RESET;
      capture_prio_reg <= `IEC_PRIO_RESET;
      ext_prio_reg     <= `IEC_PRIO_RESET;
    end else if (wr_commit && sel == IEC_SEL_PRIO_ZERO) begin
      timer_prio_reg   <= wd[`IEC_POS_TIMER_ONE +: 3];
      compare_prio_reg <= wd[`IEC_POS_COMPARE_ONE +: 3];
      capture_prio_reg <= wd[`IEC_POS_CAPTURE_ONE +: 3];
      ext_prio_reg     <= wd[`IEC_POS_EXT_INT_ZERO +: 3];
    end
  end

  always_comb begin
    rd_value = '0; // R2 R4 R5
    unique case (sel)
      IEC_SEL_EN_SIX:
        rd_value[`IEC_BIT_SELFTUNE_EN] = osc_selftune_irq_en_reg; // R1
      IEC_SEL_EN_SEVEN:
        rd_value[`IEC_BIT_JTAG_EN] = jtag_irq_en_reg; // R3
      IEC_SEL_PRIO_ZERO:
        rd_value = prio_word(timer_prio_reg, compare_prio_reg,
                             capture_prio_reg, ext_prio_reg);
      IEC_SEL_FLAG_STATUS:
        rd_value[NS-1:0] = flag_reg;
      IEC_SEL_FLAG_ENABLE:
        rd_value[NS-1:0] = enable_vec;
      IEC_SEL_FLAG_CLEAR,
      IEC_SEL_NONE:
        rd_value = '0;
    endcase
  end

  iec_apb_port u_apb (
    .clock    (clock),
    .rst      (rst),
    .psel     (psel),
    .penable  (penable),
    .hit      (sel != IEC_SEL_NONE),
    .rd_value (rd_value),
    .pready   (pready),
    .pslverr  (pslverr),
    .prdata   (prdata)
  );

  iec_flag_gate #(.N(NS)) u_flags (
    .clock     (clock),
    .rst       (rst),
    .event_in  (event_vec),
    .clear_in  (clear_vec),
    .enable_in (enable_vec),
    .flag_reg  (flag_reg),
    .req_reg   (req_reg)
  );

  // Level interrupt follows enabled flags one cycle late
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flag_reg & enable_vec); // R6 R7
    end
  end

  assign irq                   = irq_reg;
  assign selftune_req          = req_reg[`IEC_FLAG_SELFTUNE]; // R7
  assign jtag_req              = req_reg[`IEC_FLAG_JTAG]; // R7
  assign timer_one_priority    = timer_prio_reg;
  assign compare_one_priority  = compare_prio_reg;
  assign capture_one_priority  = capture_prio_reg;
  assign ext_int_zero_priority = ext_prio_reg;
endmodule : iec_enable_bank

// file: iec_regs.svh
// Register offsets, field positions and reset values of the enable bank
`ifndef IEC_REGS_SVH
`define IEC_REGS_SVH

`define IEC_OFS_EN_SIX       12'h000
`define IEC_OFS_EN_SEVEN     12'h004
`define IEC_OFS_PRIO_ZERO    12'h008
`define IEC_OFS_FLAG_STATUS  12'h00c
`define IEC_OFS_FLAG_CLEAR   12'h010
`define IEC_OFS_FLAG_ENABLE  12'h014

`define IEC_BIT_SELFTUNE_EN  10
`define IEC_BIT_JTAG_EN      5

`define IEC_FLAG_SELFTUNE    0
`define IEC_FLAG_JTAG        1
`define IEC_NUM_SRC          2

`define IEC_POS_TIMER_ONE    12
`define IEC_POS_COMPARE_ONE  8
`define IEC_POS_CAPTURE_ONE  4
`define IEC_POS_EXT_INT_ZERO 0
`define IEC_PRIO_RESET       3'h4

`endif

// file: iec_pkg.sv
// Types shared by the interrupt enable bank
package iec_pkg;
  typedef logic [15:0] iec_word_t;
  typedef logic [2:0]  iec_prio_t;
  typedef enum logic [2:0] {
    IEC_SEL_NONE,
    IEC_SEL_EN_SIX,
    IEC_SEL_EN_SEVEN,
    IEC_SEL_PRIO_ZERO,
    IEC_SEL_FLAG_STATUS,
    IEC_SEL_FLAG_CLEAR,
    IEC_SEL_FLAG_ENABLE
  } iec_sel_t;
endpackage : iec_pkg

// file: iec_flag_gate.sv
// Sticky source flags and the gated requests handed to the priority logic
module iec_flag_gate #(
  parameter int N = 2
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [N-1:0] event_in,
  input  wire logic [N-1:0] clear_in,
  input  wire logic [N-1:0] enable_in,
  output logic      [N-1:0] flag_reg,
  output logic      [N-1:0] req_reg
);
  // A flag sets regardless of its enable; a set in the clearing cycle wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= (flag_reg & ~clear_in) | event_in; // R7
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_reg <= '0;
    end else begin
      req_reg <= flag_reg & enable_in; // R7 R6
    end
  end
endmodule : iec_flag_gate

// file: iec_apb_port.sv
// APB answer stage: one wait-free access phase, registered read data
module iec_apb_port (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        hit,
  input  wire logic [15:0] rd_value,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata
);
  logic setup;
  assign setup = psel & ~penable;

  // Answer is prepared in the setup cycle so every output is a flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= {16'h0, rd_value};
    end
  end
endmodule : iec_apb_port

// file: iec_enable_bank_assertions.sv
// Concurrent checks on the ports of the interrupt enable bank
`include "iec_regs.svh"
module iec_enable_bank_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        selftune_req,
  input wire logic        jtag_req,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Write, one idle cycle, then a read of the same word
  property p_back(logic [11:0] ofs, int b);
    pready && pwrite && paddr == ofs ##2 psel && !penable && !pwrite &&
      paddr == ofs ##1 pready |-> prdata[b] == $past(pwdata[b], 3);
  endproperty
  a_six_enable: assert property (p_back(`IEC_OFS_EN_SIX, 10))
    else $error("enable six bit lost");
  a_seven_enable: assert property (p_back(`IEC_OFS_EN_SEVEN, 5))
    else $error("enable seven bit lost");
  a_six_unused: assert property (pready && !pwrite &&
    paddr == `IEC_OFS_EN_SIX |-> (prdata & ~32'h400) == 32'h0)
    else $error("enable six spare bits set");
  a_seven_high: assert property (pready && !pwrite &&
    paddr == `IEC_OFS_EN_SEVEN |-> prdata[15:6] == 10'h0)
    else $error("enable seven high bits set");
  a_seven_low: assert property (pready && !pwrite &&
    paddr == `IEC_OFS_EN_SEVEN |-> prdata[4:0] == 5'h0)
    else $error("enable seven low bits set");
  a_disable_drop: assert property (pready && pwrite &&
    paddr == `IEC_OFS_EN_SEVEN && !pwdata[5] |-> ##2 !jtag_req)
    else $error("request survives disable");
  a_irq_level: assert property (irq == (selftune_req || jtag_req))
    else $error("irq differs from requests");
  c_refused: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_jtag: cover property ($rose(jtag_req));
endmodule : iec_enable_bank_chk
bind iec_enable_bank iec_enable_bank_chk u_chk (.clock(clock), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .selftune_req(selftune_req), .jtag_req(jtag_req), .irq(irq));

// file: iec_enable_bank_tb.sv
// Self-checking bench for the interrupt enable bank
`include "iec_regs.svh"
module iec_enable_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic        st_req, jt_req, err;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, rd, d;
  logic [1:0]  ev;
  logic [2:0]  pr_t, pr_o, pr_c, pr_e;
  int          err_total = 0, check_count = 0, seed = 32'h736c;
  iec_enable_bank dut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .selftune_event(ev[0]), .jtag_event(ev[1]), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .selftune_req(st_req),
    .jtag_req(jt_req), .timer_one_priority(pr_t),
    .compare_one_priority(pr_o), .capture_one_priority(pr_c),
    .ext_int_zero_priority(pr_e), .irq(irq));
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input string       n,
                     input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task automatic xfer(input logic        w,
                      input logic [11:0] ad,
                      input logic [31:0] v);
    int i;
    @(posedge clock);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= v;
    @(posedge clock);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      results();
    end else begin
      rd = prdata;
      err = pslverr;
      psel    <= 0;
      penable <= 0;
    end
  endtask : xfer
  // Only the one enable bit of each enable word and the four priority fields survive a write
  function automatic logic [31:0] ex(input logic [11:0] ad,
                                     input logic [31:0] v);
    if (ad == `IEC_OFS_EN_SIX) return v & 32'h400;
    if (ad == `IEC_OFS_EN_SEVEN) return v & 32'h20;
    if (ad == `IEC_OFS_PRIO_ZERO) return v & 32'h7777;
    return 32'h0;
  endfunction : ex
  // Priority fields as they should appear on the output pins
  function automatic logic [11:0] pins(input logic [31:0] v);
    return {v[14:12], v[10:8], v[6:4], v[2:0]};
  endfunction : pins
  initial begin
    rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; ev = 0;
    repeat (5) @(posedge clock);
    rst <= 0;
    xfer(0, `IEC_OFS_EN_SIX, 0); chk("six reset", 0, rd);
    xfer(0, `IEC_OFS_EN_SEVEN, 0); chk("seven reset", 0, rd);
    xfer(0, `IEC_OFS_PRIO_ZERO, 0);
    chk("prio reset", 32'h4444, rd);
    chk("prio pins", pins(32'h4444), {pr_t, pr_o, pr_c, pr_e});
    for (int k = 0; k < 24; k++) begin
      a = (k % 3 == 0) ? `IEC_OFS_EN_SIX :
          (k % 3 == 1) ? `IEC_OFS_EN_SEVEN : `IEC_OFS_PRIO_ZERO;
      d = (k < 3) ? 32'hffffffff : $random(seed);
      xfer(1, a, d);
      xfer(0, a, 0); chk("readback", ex(a, d), rd);
      if (a == `IEC_OFS_PRIO_ZERO) begin
        chk("prio pins", pins(d), {pr_t, pr_o, pr_c, pr_e});
      end
    end
    xfer(1, 12'h020, 32'hffff); chk("unmapped err", 1, err);
    xfer(0, 12'h020, 0); chk("unmapped data", 0, rd);
    for (int s = 0; s < 2; s++) begin
      a = s ? `IEC_OFS_EN_SEVEN : `IEC_OFS_EN_SIX;
      xfer(1, a, 0);
      xfer(1, `IEC_OFS_FLAG_CLEAR, 3);
      @(posedge clock) ev <= 2'h1 << s;
      @(posedge clock) ev <= 0;
      xfer(0, `IEC_OFS_FLAG_STATUS, 0); chk("flag", 1 << s, rd);
      chk("masked req", 0, {jt_req, st_req});
      chk("masked irq", 0, irq);
      xfer(1, a, s ? 32'h20 : 32'h400);
      xfer(0, a, 0); chk("req", 1 << s, {jt_req, st_req});
      chk("irq", 1, irq);
      xfer(1, `IEC_OFS_FLAG_CLEAR, 1 << s);
      xfer(0, `IEC_OFS_FLAG_STATUS, 0); chk("cleared", 0, rd);
      chk("irq off", 0, irq);
    end
    xfer(0, `IEC_OFS_FLAG_ENABLE, 0); chk("enable alias", 3, rd);
    xfer(1, `IEC_OFS_FLAG_ENABLE, 32'h2);
    xfer(0, `IEC_OFS_EN_SIX, 0);
    chk("alias six", 0, rd);
    xfer(0, `IEC_OFS_EN_SEVEN, 0);
    chk("alias seven", 32'h20, rd);
    // Events land on the clearing edge: the set has to win
    fork
      xfer(1, `IEC_OFS_FLAG_CLEAR, 3);
      begin
        repeat (2) @(posedge clock);
        ev <= 2'h3;
        @(posedge clock);
        ev <= 0;
      end
    join
    xfer(0, `IEC_OFS_FLAG_STATUS, 0);
    chk("set wins", 3, rd);
    chk("req set wins", 2, {jt_req, st_req});
    xfer(0, `IEC_OFS_FLAG_CLEAR, 0);
    chk("clear reads", 0, rd);
    xfer(1, `IEC_OFS_EN_SIX, 32'h400);
    // Second reset in mid-run, with enables and fields away from reset
    rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    xfer(0, `IEC_OFS_EN_SIX, 0);
    chk("six rerst", 0, rd);
    xfer(0, `IEC_OFS_EN_SEVEN, 0);
    chk("seven rerst", 0, rd);
    chk("irq rerst", 0, irq);
    xfer(0, `IEC_OFS_PRIO_ZERO, 0);
    chk("prio rerst", 32'h4444, rd);
    chk("prio pins", pins(32'h4444), {pr_t, pr_o, pr_c, pr_e});
    results();
  end
endmodule : iec_enable_bank_tb
